/* File: rtl/spi_cmd_pkg.sv */
package spi_cmd_pkg;

  // Width of one command byte and of the status words.
  localparam int CMD_W = 8;

  // Opcodes held in the three most significant command bits.
  localparam logic [2:0] OP_QUERY    = 3'h0;
  localparam logic [2:0] OP_MASK     = 3'h1;
  localparam logic [2:0] OP_MODE     = 3'h2;
  localparam logic [2:0] OP_CLEAR    = 3'h3;
  localparam logic [2:0] OP_DEADTIME = 3'h4;

  // Command bit that picks the upper half for enable and clear commands.
  localparam int HALF_SEL_BIT = 4;
  // Mode command field positions.
  localparam int MODE_LOCK_BIT   = 0;
  localparam int MODE_FULLON_BIT = 1;
  localparam int MODE_DESAT_BIT  = 3;
  // Deadtime command bit: one asks for calibration, zero sets zero deadtime.
  localparam int DT_CAL_BIT = 0;

  // Status register 0 bit positions.
  localparam int ST_THERMAL  = 0;
  localparam int ST_DESAT    = 1;
  localparam int ST_SUPPLY   = 2;
  localparam int ST_OVERCUR  = 3;
  localparam int ST_PHASE    = 4;
  localparam int ST_FRAMING  = 5;
  localparam int ST_WRITEERR = 6;
  localparam int ST_RESETEVT = 7;

  // Reset values.
  localparam logic [3:0] IRQ_EN_LOW_RST  = 4'hf;
  localparam logic [3:0] IRQ_EN_HIGH_RST = 4'hf;
  localparam logic [7:0] STATUS0_RST     = 8'h80;

  // Raw fault conditions from the analog detectors and drive logic.
  typedef struct packed {
    logic [2:0] thermalLimit;  // Per channel overtemperature.
    logic [2:0] desat;         // Per channel desaturation.
    logic       gateSupplyLow; // Gate supply undervoltage.
    logic       overcurrent;   // Overcurrent comparator output.
    logic [2:0] phaseCmp;      // Phase comparator outputs.
    logic [2:0] driveState;    // Commanded high side state per phase.
    logic       desatBlank;    // Desaturation blanking interval active.
  } raw_fault_t;

  // Mode settings loaded by the mode command.
  typedef struct packed {
    logic desatMode;
    logic fullOn;
    logic modeLock;
  } mode_cfg_t;

endpackage : spi_cmd_pkg

/* File: rtl/spi_fault_irq_command_unit.sv */
`timescale 1ns/10ps
module spi_fault_irq_command_unit
  import spi_cmd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       spiClk,
  input  wire logic       spiCsN,
  input  wire logic       spiSi,
  input  wire raw_fault_t rawFault,
  input  wire logic       disableEvent,
  input  wire logic [7:0] status1,
  input  wire logic [7:0] status2,
  input  wire logic [7:0] status3,
  output logic            spiSo,
  output logic            spiSoEn,
  output logic            irqOut,
  output mode_cfg_t       modeCfg,
  output logic            deadtimeCmd,
  output logic            deadtimeCal
);

  // Pin synchronisers; the third stage of clock and select feeds edge finding.
  logic [2:0] csSync_r;   // Chip select chain.
  logic [2:0] sckSync_r;  // Serial clock chain.
  logic [1:0] siSync_r;   // Serial data chain.
  raw_fault_t faultS1_r;  // First stage of the raw fault inputs.
  raw_fault_t faultS2_r;  // Raw faults safe to read.
  logic [1:0] disSync_r;  // Disable event chain.

  // Serial shift state.
  logic [7:0] rx_r, rx_nxt;      // Last eight bits received.
  logic [7:0] tx_r, tx_nxt;      // Outgoing response and pass-through.
  logic [2:0] cnt_r, cnt_nxt;    // Bits received modulo eight.
  logic       seen_r, seen_nxt;  // At least one bit clocked this frame.
  logic [7:0] snap_r, snap_nxt;  // Latches as they stood at frame start.
  logic       soEn_r, soEn_nxt;  // Output drive enable.

  // Fault, enable and mode state.
  logic [7:0] latch_r, latch_nxt;        // Status register 0 latches.
  logic [3:0] enLow_r, enLow_nxt;        // irq_enable_low_half.
  logic [3:0] enHigh_r, enHigh_nxt;      // irq_enable_high_half.
  mode_cfg_t  mode_r, mode_nxt;          // Mode settings.
  logic [1:0] respSel_r, respSel_nxt;    // Status word for next frame.
  logic       awaitCal_r, awaitCal_nxt;  // Next frame is a calibration pulse.
  logic       dtCmd_r, dtCmd_nxt;        // Deadtime command pulse.
  logic       dtCal_r, dtCal_nxt;        // Calibration requested with it.
  logic       irq_r, irq_nxt;            // Interrupt output.

  // Decoded events and helpers.
  logic       csLow;      // Frame in progress.
  logic       csFall;     // Frame starts.
  logic       csRise;     // Frame ends.
  logic       sckRise;    // Bit sampled.
  logic       sckFall;    // Bit shifted out.
  logic       framing;    // Frame bit count not a whole byte.
  logic [2:0] opcode;     // Opcode of the received byte.
  logic [7:0] rawSet;     // Conditions that set latches this cycle.
  logic [7:0] clrMask;    // Latches cleared by this frame.
  logic [7:0] errSet;     // Errors flagged by this frame.
  logic [7:0] respWord;   // Status word loaded at frame start.
  logic       phaseErr;   // Derived phase error.

  // Synchronisers only register; the first stages are read by nothing else.
  // Select resets high and clock low, the idle levels of the pins, so no
  // false edge is seen when reset is released.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csSync_r  <= 3'h7;
      sckSync_r <= 3'h0;
      siSync_r  <= 2'h0;
      faultS1_r <= '0;
      faultS2_r <= '0;
      disSync_r <= 2'h0;
    end else begin
      csSync_r  <= {csSync_r[1:0], spiCsN};
      sckSync_r <= {sckSync_r[1:0], spiClk};
      siSync_r  <= {siSync_r[0], spiSi};
      faultS1_r <= rawFault;
      faultS2_r <= faultS1_r;
      disSync_r <= {disSync_r[0], disableEvent};
    end
  end

  // Edges come from the second and third stages only.
  assign csLow   = ~csSync_r[1];
  assign csFall  = csSync_r[2] & ~csSync_r[1];
  assign csRise  = ~csSync_r[2] & csSync_r[1];
  assign sckRise = ~sckSync_r[2] & sckSync_r[1] & csLow;
  assign sckFall = sckSync_r[2] & ~sckSync_r[1] & csLow;

  // Phase error is masked while blanking and in fullon mode.
  assign phaseErr = (|((faultS2_r.phaseCmp ^ faultS2_r.driveState)
                    & ~{3{faultS2_r.desatBlank}}))
                    & ~mode_r.fullOn;

  // Any active condition sets its latch every cycle it is present.
  always_comb begin
    rawSet = 8'h00;
    rawSet[ST_THERMAL]  = |faultS2_r.thermalLimit;
    rawSet[ST_DESAT]    = |faultS2_r.desat;
    rawSet[ST_SUPPLY]   = faultS2_r.gateSupplyLow;
    rawSet[ST_OVERCUR]  = faultS2_r.overcurrent;
    rawSet[ST_PHASE]    = phaseErr;
    rawSet[ST_RESETEVT] = disSync_r[1];
  end

  // Response word picked by the previous query; status 0 by default.
  always_comb begin
    unique case (respSel_r)
      2'h0: respWord = latch_r;
      2'h1: respWord = status1;
      2'h2: respWord = status2;
      2'h3: respWord = status3;
    endcase
  end

  // A frame is whole only with a nonzero multiple of eight bits.
  // A frame with no clock at all is refused too; the calibration pulse is
  // the one exception, and the decode below excuses it.
  assign framing = ~seen_r | (cnt_r != 3'h0);
  assign opcode  = rx_r[7:5];

  // Serial shifting: sample on rising clock, shift out on falling clock.
  always_comb begin
    rx_nxt   = rx_r;
    tx_nxt   = tx_r;
    cnt_nxt  = cnt_r;
    seen_nxt = seen_r;
    snap_nxt = snap_r;
    soEn_nxt = csLow;
    if (csFall) begin
      // The snapshot fixes what the host sees for this frame.
      tx_nxt   = respWord;
      cnt_nxt  = 3'h0;
      seen_nxt = 1'b0;
      snap_nxt = latch_r;
    end else if (sckRise) begin
      // Older bits fall off the top, so only the last byte is kept.
      rx_nxt   = {rx_r[6:0], siSync_r[1]};
      cnt_nxt  = cnt_r + 3'h1;
      seen_nxt = 1'b1;
    end else if (sckFall) begin
      // Received bits follow the response out for daisy chains.
      // The pass-through lags the input by exactly one byte.
      tx_nxt = {tx_r[6:0], rx_r[0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_r   <= 8'h00;
      tx_r   <= 8'h00;
      cnt_r  <= 3'h0;
      seen_r <= 1'b0;
      snap_r <= 8'h00;
      soEn_r <= 1'b0;
    end else begin
      rx_r   <= rx_nxt;
      tx_r   <= tx_nxt;
      cnt_r  <= cnt_nxt;
      seen_r <= seen_nxt;
      snap_r <= snap_nxt;
      soEn_r <= soEn_nxt;
    end
  end

  // Command decode at the end of each frame, plus latch upkeep.
  always_comb begin
    clrMask      = 8'h00;
    errSet       = 8'h00;
    enLow_nxt    = enLow_r;
    enHigh_nxt   = enHigh_r;
    mode_nxt     = mode_r;
    respSel_nxt  = respSel_r;
    awaitCal_nxt = awaitCal_r;
    dtCmd_nxt    = 1'b0;
    dtCal_nxt    = dtCal_r;
    if (csRise) begin
      awaitCal_nxt = 1'b0;
      if (framing) begin
        // A clockless calibration pulse is expected, not an error.
        if (!(awaitCal_r && !seen_r)) begin
          errSet[ST_FRAMING] = 1'b1;
        end
      end else begin
        respSel_nxt = 2'h0;
        unique case (opcode)
          OP_QUERY: begin
            // A query only picks the word returned by the next frame.
            respSel_nxt = rx_r[1:0];
          end
          OP_MASK: begin
            if (mode_r.modeLock) begin
              errSet[ST_WRITEERR] = 1'b1;
            end else if (rx_r[HALF_SEL_BIT]) begin
              enHigh_nxt = rx_r[3:0];
            end else begin
              enLow_nxt = rx_r[3:0];
            end
          end
          OP_MODE: begin
            // Setting the lock in the same command is allowed.
            if (mode_r.modeLock) begin
              errSet[ST_WRITEERR] = 1'b1;
            end else begin
              mode_nxt.desatMode = rx_r[MODE_DESAT_BIT];
              mode_nxt.fullOn    = rx_r[MODE_FULLON_BIT];
              mode_nxt.modeLock  = rx_r[MODE_LOCK_BIT];
            end
          end
          OP_CLEAR: begin
            // Only bits unchanged since the frame began may clear.
            if (rx_r[HALF_SEL_BIT]) begin
              clrMask[7:4] = rx_r[3:0];
            end else begin
              clrMask[3:0] = rx_r[3:0];
            end
            clrMask = clrMask & ~(snap_r ^ latch_r);
          end
          OP_DEADTIME: begin
            if (mode_r.modeLock) begin
              errSet[ST_WRITEERR] = 1'b1;
            end else begin
              dtCmd_nxt    = 1'b1;
              dtCal_nxt    = rx_r[DT_CAL_BIT];
              awaitCal_nxt = rx_r[DT_CAL_BIT];
            end
          end
          default: begin
            // Unused opcodes leave every setting alone.
          end
        endcase
      end
    end
    // Errors found by this frame enter the same way as pin faults.
    // Set wins over clear, so a live fault keeps its latch.
    latch_nxt = (latch_r & ~clrMask) | rawSet | errSet;
    // The line follows the enables at once, so masking a pending fault
    // drops it without clearing the latch; the host must clear it later.
    // Built from next values, the line cannot dip while faults remain.
    irq_nxt = |(latch_nxt & {enHigh_nxt, enLow_nxt});
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Reset event latch comes up set; all else at defaults.
      latch_r    <= STATUS0_RST;
      enLow_r    <= IRQ_EN_LOW_RST;
      enHigh_r   <= IRQ_EN_HIGH_RST;
      mode_r     <= '0;
      respSel_r  <= 2'h0;
      awaitCal_r <= 1'b0;
      dtCmd_r    <= 1'b0;
      dtCal_r    <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      latch_r    <= latch_nxt;
      enLow_r    <= enLow_nxt;
      enHigh_r   <= enHigh_nxt;
      mode_r     <= mode_nxt;
      respSel_r  <= respSel_nxt;
      awaitCal_r <= awaitCal_nxt;
      dtCmd_r    <= dtCmd_nxt;
      dtCal_r    <= dtCal_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Every output is a flip-flop.
  // The serial output comes from the top of the shift register, so the
  // first response bit is ready as soon as the drive enable rises.
  assign spiSo       = tx_r[7];
  assign spiSoEn     = soEn_r;
  assign irqOut      = irq_r;
  assign modeCfg     = mode_r;
  assign deadtimeCmd = dtCmd_r;
  assign deadtimeCal = dtCal_r;

endmodule : spi_fault_irq_command_unit

/* File: sim/spi_fault_irq_properties.sv */
`timescale 1ns/10ps
// Port level checks of the command unit, bound to every instance.
module spi_fault_irq_properties
  import spi_cmd_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire logic      spiCsN,
  input wire logic      irqOut,
  input wire mode_cfg_t modeCfg,
  input wire logic      deadtimeCmd,
  input wire logic      deadtimeCal
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // The reset event is latched and enabled, so the line rises at once.
  property p_irq_exit; $fell(rst) |-> ##[0:2] irqOut; endproperty
  a_irq_exit: assert property (p_irq_exit) else $error("no irq");
  // Clears act only after select has gone high.
  property p_irq_fall;
    $fell(irqOut) |-> spiCsN && $past(spiCsN, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("early drop");
  // Settings change only after the frame is closed.
  property p_mode_upd;
    $changed(modeCfg) |-> spiCsN && $past(spiCsN, 2);
  endproperty
  a_mode_upd: assert property (p_mode_upd) else $error("mode upd");
  // Lock can only be set; reset alone clears it.
  property p_lock_keep;
    $past(modeCfg.modeLock) |-> modeCfg.modeLock;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock");
  // Once locked, no mode write may land.
  property p_lock_frz; $past(modeCfg.modeLock) |-> $stable(modeCfg); endproperty
  a_lock_frz: assert property (p_lock_frz) else $error("frozen");
  // The deadtime strobe is one cycle long and comes after the frame.
  property p_dt_pulse; deadtimeCmd |-> spiCsN ##1 !deadtimeCmd; endproperty
  a_dt_pulse: assert property (p_dt_pulse) else $error("pulse");
  // The calibrate flag moves only with an accepted command.
  property p_dt_cal; $changed(deadtimeCal) |-> deadtimeCmd; endproperty
  a_dt_cal: assert property (p_dt_cal) else $error("cal");
  // Deadtime writes are refused while locked.
  property p_dt_lock; $past(modeCfg.modeLock) |-> !deadtimeCmd; endproperty
  a_dt_lock: assert property (p_dt_lock) else $error("dt lock");
endmodule : spi_fault_irq_properties

bind spi_fault_irq_command_unit spi_fault_irq_properties props (
  .ref_clk(ref_clk), .rst(rst), .spiCsN(spiCsN), .irqOut(irqOut),
  .modeCfg(modeCfg), .deadtimeCmd(deadtimeCmd), .deadtimeCal(deadtimeCal));

/* File: sim/spi_host_model.sv */
`timescale 1ns/10ps
// Host that masters the link: clock idles low, data MSB first.
module spi_host_model (
  output logic     spiClk,
  output logic     spiCsN,
  output logic     spiSi,
  input wire logic spiSo
);
  // Idle link: clock still, select high.
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiSi  = 1'b0;
  end
  // Sends n bits; resp keeps the last eight bits read back.
  task automatic xfer(input logic [15:0] b, input int n,
                      output logic [7:0] resp);
    resp = 8'h00;
    #13 spiCsN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spiSi = b[i];
      #400 spiClk = 1'b1;
      // Read just before the fall, while the answer bit still stands.
      #400 resp = {resp[6:0], spiSo};
      spiClk = 1'b0;
    end
    #400 spiCsN = 1'b1;
    spiSi = ~spiSi; // A released line must not show the old bit.
    #1000;
  endtask : xfer
endmodule : spi_host_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench of the command and fault interrupt unit.
module tb_top;
  import spi_cmd_pkg::*;
  logic       ref_clk      = 1'b0; // Main clock.
  logic       rst          = 1'b1; // Reset, held at start.
  raw_fault_t rawFault     = '0;   // Fault levels.
  logic       disableEvent = 1'b0; // Disable input.
  logic       spiClk, spiCsN, spiSi, spiSo, spiSoEn; // Link wires.
  logic       irqOut, deadtimeCmd, deadtimeCal;      // Unit outputs.
  mode_cfg_t  modeCfg;                               // Mode settings.
  logic [7:0] resp;                                  // Last answer.
  int         dtPulses     = 0;                      // Deadtime strobes.
  // A released output reads inverted, so a late enable shows as a mismatch.
  wire        soLine       = spiSoEn ? spiSo : ~spiSo;
  int         num_errors   = 0;                      // Mismatches.
  int         comparisons  = 0;                      // Compares.
  // Clock of 100 ns period.
  always #50 ref_clk = ~ref_clk;
  // Counts deadtime strobes in the settled half of the cycle.
  always @(negedge ref_clk) begin
    if (deadtimeCmd) begin
      dtPulses++;
    end
  end
  spi_host_model host (.spiClk(spiClk), .spiCsN(spiCsN), .spiSi(spiSi),
                       .spiSo(soLine));
  spi_fault_irq_command_unit DUT (
    .ref_clk(ref_clk), .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiSi(spiSi), .rawFault(rawFault), .disableEvent(disableEvent),
    .status1(8'h11), .status2(8'h22), .status3(8'h33), .spiSo(spiSo),
    .spiSoEn(spiSoEn), .irqOut(irqOut), .modeCfg(modeCfg),
    .deadtimeCmd(deadtimeCmd), .deadtimeCal(deadtimeCal));
  // Compares and counts.
  task automatic check(input string w, input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : check
  // One frame, then the answer is judged.
  task automatic cmd(input logic [15:0] b, input int n, input logic [7:0] e);
    host.xfer(b, n, resp);
    // Back on the falling edge, where the bench drives its inputs.
    @(negedge ref_clk);
    check("resp", resp, e);
  endtask : cmd
  // Waits for synchronisers and latches to settle.
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask : settle
  // Reset state, first answer, status selection, reset event clear.
  task automatic t_reset();
    logic [7:0] e [4] = '{8'h80, 8'h11, 8'h22, 8'h33};
    check("irq", irqOut, 1'b1);
    check("mode", modeCfg, 8'h00);
    check("soen", spiSoEn, 1'b0);
    for (int s = 1; s <= 4; s++) cmd(8'(s % 4), 8, e[s - 1]);
    cmd(8'h78, 8, 8'h80);
    check("irq", irqOut, 1'b0);
    cmd(8'h00, 8, 8'h00);
  endtask : t_reset
  // Latching, masking and clearing of low half faults.
  task automatic t_latch();
    @(negedge ref_clk) rawFault.thermalLimit[1] = 1'b1;
    settle();
    rawFault.thermalLimit[1] = 1'b0;
    settle();
    check("irq", irqOut, 1'b1);
    cmd({8'hc3, 8'h20}, 16, 8'hc3);
    check("irq", irqOut, 1'b0);
    cmd(8'h2f, 8, 8'h01);
    check("irq", irqOut, 1'b1);
    rawFault.overcurrent = 1'b1;
    settle();
    cmd(8'h6f, 8, 8'h09);
    check("irq", irqOut, 1'b1);
    cmd(8'h00, 8, 8'h08);
    rawFault.overcurrent = 1'b0;
    settle();
    cmd(8'h68, 8, 8'h08);
    check("irq", irqOut, 1'b0);
  endtask : t_latch
  // Phase blanking, low half flags, short frame and a disable event.
  task automatic t_frame();
    rawFault.desatBlank    = 1'b1;
    rawFault.phaseCmp      = 3'h1;
    rawFault.desat[2]      = 1'b1;
    rawFault.gateSupplyLow = 1'b1;
    settle();
    rawFault.desat[2]      = 1'b0;
    rawFault.gateSupplyLow = 1'b0;
    cmd(8'h00, 8, 8'h06);
    rawFault.desatBlank = 1'b0;
    settle();
    rawFault.phaseCmp = 3'h0;
    settle();
    check("irq", irqOut, 1'b1);
    cmd(8'h66, 8, 8'h16);
    cmd(8'h71, 8, 8'h10);
    check("irq", irqOut, 1'b0);
    cmd(8'h7f, 7, 8'h00);
    disableEvent = 1'b1;
    settle();
    disableEvent = 1'b0;
    settle();
    check("irq", irqOut, 1'b1);
    cmd(8'h00, 8, 8'ha0);
    cmd(8'h7a, 8, 8'ha0);
    check("irq", irqOut, 1'b0);
  endtask : t_frame
  // Deadtime, mode lock, refused writes, unused opcodes, phase masking in fullon mode.
  task automatic t_lock();
    cmd(8'h81, 8, 8'h00);
    host.xfer(16'h0000, 0, resp);
    check("cal", deadtimeCal, 1'b1);
    cmd(8'h4b, 8, 8'h00);
    check("mode", modeCfg, 8'h07);
    cmd(8'h20, 8, 8'h00);
    cmd(8'h80, 8, 8'h40);
    check("cal", deadtimeCal, 1'b1);
    check("dtcmd", 8'(dtPulses), 8'h01);
    for (int o = 5; o < 8; o++) cmd({3'(o), 5'h1f}, 8, 8'h40);
    rawFault.phaseCmp = 3'h7;
    settle();
    cmd(8'h00, 8, 8'h40);
    check("irq", irqOut, 1'b1);
  endtask : t_lock
  // Reset in mid-run after lock: settings, latches and answer start over.
  task automatic t_rerst();
    @(negedge ref_clk) rst = 1'b1;
    rawFault.phaseCmp = 3'h0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    settle();
    check("mode", modeCfg, 8'h00);
    check("cal", deadtimeCal, 1'b0);
    check("irq", irqOut, 1'b1);
    cmd(8'h01, 8, 8'h80);
    cmd(8'h20, 8, 8'h11);
    cmd(8'h00, 8, 8'h80);
  endtask : t_rerst
  // Prints the verdict and stops.
  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence.
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    settle();
    t_reset();
    t_latch();
    t_frame();
    t_lock();
    t_rerst();
    end_sim();
  end
  // Cuts a hang short.
  initial begin
    #2000000 num_errors++;
    end_sim();
  end
endmodule : tb_top
